/* File: modem_cmd_defs.svh */
`ifndef MODEM_CMD_DEFS_SVH
`define MODEM_CMD_DEFS_SVH

// Command opcodes
`define OP_NOP 8'h00
`define OP_HANDSHAKE 8'h04
`define OP_RETRAIN 8'h05
`define OP_INIT 8'h06
`define OP_FE_READ1 8'h08
`define OP_FE_READ2 8'h09
`define OP_TONE_GEN_ENABLE 8'h0D
`define OP_TONE1_STEP 8'h0E
`define OP_TONE2_STEP 8'h0F
`define OP_FREEZE_EC 8'h16
`define OP_UNFREEZE_EC 8'h17
`define OP_SCRAMBLER 8'h18
`define OP_FREEZE_EQ 8'h1B
`define OP_UNFREEZE_EQ 8'h1C
`define OP_CFG_LOWSPEED 8'h1E
`define OP_CFG_HIGHSPEED 8'h20

// Parameter byte fields
`define LS_GUARD_HI 7
`define LS_GUARD_LO 6
`define CFG_LOOPBACK 3
`define CFG_RATE_HI 2
`define CFG_RATE_LO 1
`define CFG_ORIGINATE 0
`define HS_FORCE_CLEARDOWN 5
`define HS_CANCELLER 4
`define ATTEN_HI 7
`define ATTEN_LO 4
`define LS_LEASED 1
`define LS_FALLBACK 0
`define PARAM_FLAG 0

// Reserved-bit masks applied by the host
`define LS_B1_MASK 8'hCF
`define LS_B2_MASK 8'hF3
`define HS_B1_MASK 8'h3F
`define HS_B2_MASK 8'hF0
`define FLAG_B2_MASK 8'h01
`define TONE_GEN_ENABLE_CMD_B1_MASK 8'h03

// Attenuation, carrier detect and tone limits
`define ATTEN_MAX_CODE 4'hB
`define CD_PSTN_ON 6'h2B
`define CD_PSTN_OFF 6'h30
`define CD_LEASED_ON 6'h21
`define CD_LEASED_OFF 6'h26
`define TONE_FULL_AMPLITUDE_STEP 16'h6AAA

// Host register map and reset values
`define REG_CMD 4'h0
`define REG_STATUS 4'h4
`define REG_RESP 4'h8
`define STATUS_BUSY 0
`define STATUS_RESP_AVAIL 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESET_SCRAMBLER_ON 1'b1

`endif

/* File: modem_cmd_pkg.sv */
package modem_cmd_pkg;

   typedef enum logic [2:0] {
      RATE_V22BIS_2400, RATE_V22_1200, RATE_US_QAM_1200, RATE_V22_600,
      RATE_HS_9600, RATE_HS_9600_TRELLIS, RATE_HS_4800, RATE_HS_2400
   } rate_type;

   typedef enum logic [1:0] {DEV_COLLECT, DEV_RESPOND} dev_phase_type;

   typedef enum logic [1:0] {HOST_IDLE, HOST_SEND, HOST_RECEIVE}
      host_phase_type;

   typedef struct packed {
      dev_phase_type phase;
      logic [1:0] count;
      logic [7:0] opcode;
      logic [7:0] param1;
      logic [23:0] respShift;
      rate_type rateMode;
      logic [1:0] guardTone;
      logic loopbackTestOn;
      logic originate;
      logic [4:0] txAttenDb;
      logic txSilent;
      logic [5:0] cdOnDbm;
      logic [5:0] cdOffDbm;
      logic rateFallbackEnable;
      logic farEndCancellerOn;
      logic forceCleardown;
      logic [15:0] tone1Step;
      logic [15:0] tone2Step;
      logic tone1HighAtten;
      logic tone2HighAtten;
      logic tone1Enable;
      logic tone2Enable;
      logic echoAdaptFrozen;
      logic eqAdaptFrozen;
      logic handshakeStart;
      logic answerToneOn;
      logic handshakeRunning;
      logic initPulse;
      logic retrainStart;
      logic retrainFallback;
      logic scramblerOn;
      logic cmdDone;
   } dev_state_type;

   typedef struct packed {
      host_phase_type phase;
      logic [1:0] count;
      logic expectReply;
      logic [23:0] cmdWord;
      logic [23:0] respWord;
      logic respAvail;
      logic cmdValid;
      logic [7:0] cmdByte;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } host_state_type;

endpackage

/* File: modem_cmd_if.sv */
`timescale 1ns/100ps
interface modem_cmd_if;
   logic cmdValid;
   logic [7:0] cmdByte;
   logic cmdReady;
   logic respValid;
   logic [7:0] respByte;
   logic respReady;

   modport device (
      input cmdValid, cmdByte, respReady,
      output cmdReady, respValid, respByte
   );
   modport host (
      output cmdValid, cmdByte, respReady,
      input cmdReady, respValid, respByte
   );
endinterface

/* File: modem_cmd_device.sv */
`timescale 1ns/100ps
`include "modem_cmd_defs.svh"
// Operation
// - Opcode 1E: guard, loopback, mode, originate
// - Low-speed mode codes select four rates
// - Byte 2: attenuation, leased line, fallback
// - Leased line selects carrier thresholds
// - Opcode 20: cleardown, canceller, loopback, speed
// - High-speed code selects four rates
// - Originate bit picks calling or answering
// - Canceller on/off, force cleardown
// - Attenuation codes above 1011 silence transmitter
// - Opcode 0E loads tone 1 step
// - Loading a step never enables generator
// - Opcode 0F loads tone 2 step
// - Steps above 3 kHz flagged attenuated
// - Freeze/unfreeze canceller and equalizer
// - Opcode 04 starts handshake, optional tone
// - Handshake progress returned with status
// - Opcode 06 zero restores defaults
// - All-zero command does nothing
// - Opcodes 08/09 return three-byte register read
// - Opcode 05 retrains, picks V.22bis rate
// - Opcode 18 switches scrambler
module modem_cmd_device (
   input wire logic clock, // 20 MHz clock
   input wire logic arst_n, // Async reset
   input wire logic clockEnable, // Freezes state when low
   modem_cmd_if.device link, // Byte mailbox
   input wire logic [11:0] feRead1Data, // Front-end register 1
   input wire logic [11:0] feRead2Data, // Front-end register 2
   input wire logic [3:0] hsFlags, // Handshake progress flags
   input wire logic handshakeDone, // Handshake finished pulse
   output modem_cmd_pkg::rate_type rateMode, // Selected rate
   output logic [1:0] guardTone, // Guard tone select
   output logic loopbackTestOn, // Analog loopback
   output logic originate, // Calling modem
   output logic [4:0] txAttenDb, // Transmit attenuation dB
   output logic txSilent, // Infinite attenuation
   output logic [5:0] cdOnDbm, // Detect on level, -dBm
   output logic [5:0] cdOffDbm, // Detect off level, -dBm
   output logic rateFallbackEnable, // V.22bis fallback
   output logic farEndCancellerOn, // Far-end canceller
   output logic forceCleardown, // Cleardown pulse
   output logic [15:0] tone1Step, // Tone 1 step per sample
   output logic [15:0] tone2Step, // Tone 2 step per sample
   output logic tone1HighAtten, // Tone 1 above 3 kHz
   output logic tone2HighAtten, // Tone 2 above 3 kHz
   output logic tone1Enable, // Tone 1 on
   output logic tone2Enable, // Tone 2 on
   output logic echoAdaptFrozen, // Canceller frozen
   output logic eqAdaptFrozen, // Equalizer frozen
   output logic handshakeStart, // Handshake start pulse
   output logic answerToneOn, // Answer tone wanted
   output logic handshakeRunning, // Handshake under way
   output logic initPulse, // Restart pulse
   output logic retrainStart, // Retrain pulse
   output logic retrainFallback, // Retrain toward 1200
   output logic scramblerOn, // Transmit scrambler
   output logic cmdDone // Command executed pulse
);

   modem_cmd_pkg::dev_state_type s;
   modem_cmd_pkg::dev_state_type next_s;

   // Power-on and restart values
   function automatic modem_cmd_pkg::dev_state_type defaults();
      modem_cmd_pkg::dev_state_type d;
      d = '0;
      d.cdOnDbm = `CD_PSTN_ON;
      d.cdOffDbm = `CD_PSTN_OFF;
      d.scramblerOn = `RESET_SCRAMBLER_ON;
      return d;
   endfunction

   // Attenuation code to {silent, dB}
   function automatic logic [5:0] attenDecode(input logic [3:0] code);
      if (code > `ATTEN_MAX_CODE) begin
         attenDecode = {1'b1, 5'h00};
      end else begin
         attenDecode = {1'b0, code, 1'b0};
      end
   endfunction

   // Step above full-amplitude limit
   function automatic logic highTone(input logic [15:0] step);
      highTone = step > `TONE_FULL_AMPLITUDE_STEP;
   endfunction

   // Mailbox handshakes
   assign link.cmdReady = (s.phase == modem_cmd_pkg::DEV_COLLECT);
   assign link.respValid = (s.phase == modem_cmd_pkg::DEV_RESPOND);
   assign link.respByte = s.respShift[23:16];

   // Command collection, decode and response
   always_comb begin
      logic [7:0] b2;
      logic [5:0] att;
      logic [11:0] fe;
      b2 = link.cmdByte;
      att = attenDecode(b2[`ATTEN_HI:`ATTEN_LO]);
      fe = (s.opcode == `OP_FE_READ1) ? feRead1Data : feRead2Data;
      next_s = s;
      next_s.forceCleardown = 1'b0;
      next_s.handshakeStart = 1'b0;
      next_s.initPulse = 1'b0;
      next_s.retrainStart = 1'b0;
      next_s.cmdDone = 1'b0;
      if (handshakeDone) begin
         next_s.handshakeRunning = 1'b0;
      end
      case (s.phase)
         modem_cmd_pkg::DEV_COLLECT: begin
            if (link.cmdValid && s.count == 2'd0) begin
               next_s.opcode = link.cmdByte;
               next_s.count = 2'd1;
            end else if (link.cmdValid && s.count == 2'd1) begin
               next_s.param1 = link.cmdByte;
               next_s.count = 2'd2;
            end else if (link.cmdValid) begin
               next_s.count = 2'd0;
               next_s.cmdDone = 1'b1;
               case (s.opcode)
                  `OP_CFG_LOWSPEED: begin
                     next_s.guardTone =
                        s.param1[`LS_GUARD_HI:`LS_GUARD_LO];
                     next_s.loopbackTestOn = s.param1[`CFG_LOOPBACK];
                     next_s.originate = s.param1[`CFG_ORIGINATE];
                     case (s.param1[`CFG_RATE_HI:`CFG_RATE_LO])
                        2'b00: next_s.rateMode =
                           modem_cmd_pkg::RATE_V22BIS_2400;
                        2'b01: next_s.rateMode = modem_cmd_pkg::RATE_V22_1200;
                        2'b10: next_s.rateMode =
                           modem_cmd_pkg::RATE_US_QAM_1200;
                        default: next_s.rateMode =
                           modem_cmd_pkg::RATE_V22_600;
                     endcase
                     {next_s.txSilent, next_s.txAttenDb} = att;
                     if (b2[`LS_LEASED]) begin
                        next_s.cdOnDbm = `CD_LEASED_ON;
                        next_s.cdOffDbm = `CD_LEASED_OFF;
                     end else begin
                        next_s.cdOnDbm = `CD_PSTN_ON;
                        next_s.cdOffDbm = `CD_PSTN_OFF;
                     end
                     next_s.rateFallbackEnable = b2[`LS_FALLBACK];
                  end
                  `OP_CFG_HIGHSPEED: begin
                     next_s.forceCleardown =
                        s.param1[`HS_FORCE_CLEARDOWN];
                     next_s.farEndCancellerOn =
                        s.param1[`HS_CANCELLER];
                     next_s.loopbackTestOn = s.param1[`CFG_LOOPBACK];
                     next_s.originate = s.param1[`CFG_ORIGINATE];
                     case (s.param1[`CFG_RATE_HI:`CFG_RATE_LO])
                        2'b00: next_s.rateMode = modem_cmd_pkg::RATE_HS_9600;
                        2'b10: next_s.rateMode =
                           modem_cmd_pkg::RATE_HS_9600_TRELLIS;
                        2'b01: next_s.rateMode = modem_cmd_pkg::RATE_HS_4800;
                        default: next_s.rateMode =
                           modem_cmd_pkg::RATE_HS_2400;
                     endcase
                     {next_s.txSilent, next_s.txAttenDb} = att;
                  end
                  `OP_TONE1_STEP: begin
                     next_s.tone1Step = {b2, s.param1};
                     next_s.tone1HighAtten = highTone({b2, s.param1});
                  end
                  `OP_TONE2_STEP: begin
                     next_s.tone2Step = {b2, s.param1};
                     next_s.tone2HighAtten = highTone({b2, s.param1});
                  end
                  `OP_TONE_GEN_ENABLE: begin
                     next_s.tone1Enable = s.param1[0];
                     next_s.tone2Enable = s.param1[1];
                  end
                  `OP_FREEZE_EC: next_s.echoAdaptFrozen = 1'b1;
                  `OP_UNFREEZE_EC: next_s.echoAdaptFrozen = 1'b0;
                  `OP_FREEZE_EQ: next_s.eqAdaptFrozen = 1'b1;
                  `OP_UNFREEZE_EQ: next_s.eqAdaptFrozen = 1'b0;
                  `OP_HANDSHAKE: begin
                     next_s.handshakeStart = 1'b1;
                     next_s.handshakeRunning = 1'b1;
                     next_s.answerToneOn = ~b2[`PARAM_FLAG];
                  end
                  `OP_INIT: begin
                     if (s.param1 == 8'h00 && b2 == 8'h00) begin
                        next_s = defaults();
                        next_s.initPulse = 1'b1;
                        next_s.cmdDone = 1'b1;
                     end
                  end
                  `OP_FE_READ1, `OP_FE_READ2: begin
                     // Status byte carries handshake progress
                     next_s.respShift = {2'b11, 1'b0, s.handshakeRunning,
                        hsFlags, fe[7:0], 4'h0, fe[11:8]};
                     next_s.phase = modem_cmd_pkg::DEV_RESPOND;
                  end
                  `OP_RETRAIN: begin
                     next_s.retrainStart = 1'b1;
                     next_s.retrainFallback = b2[`PARAM_FLAG];
                     if (s.rateMode == modem_cmd_pkg::RATE_V22BIS_2400 ||
                        s.rateMode == modem_cmd_pkg::RATE_V22_1200) begin
                        next_s.rateMode = b2[`PARAM_FLAG] ?
                           modem_cmd_pkg::RATE_V22_1200 :
                           modem_cmd_pkg::RATE_V22BIS_2400;
                     end
                  end
                  `OP_SCRAMBLER: next_s.scramblerOn = b2[`PARAM_FLAG];
                  default: begin
                  end
               endcase
            end
         end
         modem_cmd_pkg::DEV_RESPOND: begin
            if (link.respReady) begin
               next_s.respShift = {s.respShift[15:0], 8'h00};
               next_s.count = s.count + 2'd1;
               if (s.count == 2'd2) begin
                  next_s.count = 2'd0;
                  next_s.phase = modem_cmd_pkg::DEV_COLLECT;
               end
            end
         end
         default: next_s.phase = modem_cmd_pkg::DEV_COLLECT;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s <= defaults();
      end else if (clockEnable) begin
         s <= next_s;
      end
   end

   // Outputs straight from state
   assign rateMode = s.rateMode;
   assign guardTone = s.guardTone;
   assign loopbackTestOn = s.loopbackTestOn;
   assign originate = s.originate;
   assign txAttenDb = s.txAttenDb;
   assign txSilent = s.txSilent;
   assign cdOnDbm = s.cdOnDbm;
   assign cdOffDbm = s.cdOffDbm;
   assign rateFallbackEnable = s.rateFallbackEnable;
   assign farEndCancellerOn = s.farEndCancellerOn;
   assign forceCleardown = s.forceCleardown;
   assign tone1Step = s.tone1Step;
   assign tone2Step = s.tone2Step;
   assign tone1HighAtten = s.tone1HighAtten;
   assign tone2HighAtten = s.tone2HighAtten;
   assign tone1Enable = s.tone1Enable;
   assign tone2Enable = s.tone2Enable;
   assign echoAdaptFrozen = s.echoAdaptFrozen;
   assign eqAdaptFrozen = s.eqAdaptFrozen;
   assign handshakeStart = s.handshakeStart;
   assign answerToneOn = s.answerToneOn;
   assign handshakeRunning = s.handshakeRunning;
   assign initPulse = s.initPulse;
   assign retrainStart = s.retrainStart;
   assign retrainFallback = s.retrainFallback;
   assign scramblerOn = s.scramblerOn;
   assign cmdDone = s.cmdDone;

endmodule

/* File: modem_cmd_host.sv */
`timescale 1ns/100ps
`include "modem_cmd_defs.svh"
module modem_cmd_host (
   input wire logic clock, // 20 MHz clock
   input wire logic arst_n, // Async reset
   input wire logic clockEnable, // Freezes state when low
   modem_cmd_if.host link, // Byte mailbox
   input wire logic [3:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [3:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready // Read data ready
);

   modem_cmd_pkg::host_state_type s;
   modem_cmd_pkg::host_state_type next_s;

   // Zero reserved parameter bits per opcode
   function automatic logic [23:0] maskReserved(input logic [23:0] w);
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      op = w[23:16];
      b1 = w[15:8];
      b2 = w[7:0];
      case (op)
         `OP_CFG_LOWSPEED: begin
            b1 = b1 & `LS_B1_MASK;
            b2 = b2 & `LS_B2_MASK;
         end
         `OP_CFG_HIGHSPEED: begin
            b1 = b1 & `HS_B1_MASK;
            b2 = b2 & `HS_B2_MASK;
         end
         `OP_HANDSHAKE, `OP_RETRAIN, `OP_SCRAMBLER: begin
            b1 = 8'h00;
            b2 = b2 & `FLAG_B2_MASK;
         end
         `OP_TONE_GEN_ENABLE: begin
            b1 = b1 & `TONE_GEN_ENABLE_CMD_B1_MASK;
            b2 = 8'h00;
         end
         `OP_TONE1_STEP, `OP_TONE2_STEP: begin
         end
         default: begin
            b1 = 8'h00;
            b2 = 8'h00;
         end
      endcase
      return {op, b1, b2};
   endfunction

   // Write channels taken together when no response is pending
   assign awready = awvalid && wvalid && !s.bvalid;
   assign wready = awready;
   assign arready = !s.rvalid;
   assign link.respReady = (s.phase == modem_cmd_pkg::HOST_RECEIVE);

   // Register bus, command sender and reply collector
   always_comb begin
      logic [23:0] w;
      w = s.cmdWord;
      for (int i = 0; i < 3; i++) begin
         if (wstrb[i]) begin
            w[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      next_s = s;
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      // Reads; reading the reply clears its flag
      if (arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         case (araddr)
            `REG_CMD: next_s.rdata = {8'h00, s.cmdWord};
            `REG_STATUS: begin
               next_s.rdata[`STATUS_BUSY] =
                  (s.phase != modem_cmd_pkg::HOST_IDLE);
               next_s.rdata[`STATUS_RESP_AVAIL] = s.respAvail;
            end
            `REG_RESP: begin
               next_s.rdata = {8'h00, s.respWord};
               next_s.respAvail = 1'b0;
            end
            default: next_s.rresp = `RESP_SLVERR;
         endcase
      end
      // Writes; a command write launches when idle
      if (awready) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = `RESP_OKAY;
         if (awaddr == `REG_CMD) begin
            if (s.phase == modem_cmd_pkg::HOST_IDLE) begin
               next_s.cmdWord = maskReserved(w);
               next_s.expectReply = (w[23:16] == `OP_FE_READ1) ||
                  (w[23:16] == `OP_FE_READ2);
               next_s.cmdByte = w[23:16];
               next_s.cmdValid = 1'b1;
               next_s.count = 2'd0;
               next_s.phase = modem_cmd_pkg::HOST_SEND;
            end
         end else if (awaddr != `REG_STATUS && awaddr != `REG_RESP) begin
            next_s.bresp = `RESP_SLVERR;
         end
      end
      case (s.phase)
         modem_cmd_pkg::HOST_IDLE: begin
         end
         modem_cmd_pkg::HOST_SEND: begin
            if (link.cmdReady) begin
               next_s.count = s.count + 2'd1;
               // Opcode first, then bytes 1 and 2
               if (s.count == 2'd0) begin
                  next_s.cmdByte = s.cmdWord[15:8];
               end else if (s.count == 2'd1) begin
                  next_s.cmdByte = s.cmdWord[7:0];
               end else begin
                  next_s.cmdValid = 1'b0;
                  next_s.count = 2'd0;
                  next_s.phase = s.expectReply ?
                     modem_cmd_pkg::HOST_RECEIVE : modem_cmd_pkg::HOST_IDLE;
               end
            end
         end
         modem_cmd_pkg::HOST_RECEIVE: begin
            if (link.respValid) begin
               next_s.respWord = {s.respWord[15:0], link.respByte};
               next_s.count = s.count + 2'd1;
               if (s.count == 2'd2) begin
                  next_s.count = 2'd0;
                  next_s.respAvail = 1'b1;
                  next_s.phase = modem_cmd_pkg::HOST_IDLE;
               end
            end
         end
         default: next_s.phase = modem_cmd_pkg::HOST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else if (clockEnable) begin
         s <= next_s;
      end
   end

   // Outputs from state
   assign link.cmdValid = s.cmdValid;
   assign link.cmdByte = s.cmdByte;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;

endmodule

/* File: modem_cmd_checker.sv */
`timescale 1ns/100ps
module modem_cmd_checker (
   input wire logic clock, // Clock
   input wire logic arst_n, // Reset
   input wire logic cmdValid, // Byte offered
   input wire logic [7:0] cmdByte, // Command byte
   input wire logic cmdReady, // Device collecting
   input wire logic respValid, // Reply offered
   input wire logic [7:0] respByte, // Reply byte
   input wire logic respReady // Host collecting
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Three bytes taken, opcode first, read or not
   sequence s_cmd(logic rd);
      $rose(cmdValid) && cmdReady && ((cmdByte[7:1] == 7'h04) == rd)
      ##1 cmdValid && cmdReady ##1 cmdValid && cmdReady;
   endsequence
   // Mailbox handshake and reply framing
   a_read_reply: assert property (s_cmd(1'b1) |=> respValid)
      else $error("no reply after register read");
   a_other_quiet: assert property (s_cmd(1'b0) |=> !respValid)
      else $error("reply after plain command");
   a_reply_three: assert property ($rose(respValid) |->
      respValid [*3] ##1 !respValid) else $error("reply not three bytes");
   a_status_flags: assert property ($rose(respValid) |->
      respByte[7:5] == 3'b110) else $error("bad status byte");
   a_high_nibble: assert property ($rose(respValid) ##2 respValid |->
      respByte[7:4] == 4'h0) else $error("bad high byte");
   a_reply_refuses: assert property (respValid |-> !cmdReady)
      else $error("command taken during reply");
   a_cmd_holds: assert property (cmdValid && !cmdReady |=>
      cmdValid && $stable(cmdByte)) else $error("command byte dropped");
   a_resp_holds: assert property (respValid && !respReady |=>
      respValid && $stable(respByte)) else $error("reply byte dropped");
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
   logic clock, arst_n, clockEnable, handshakeDone;
   logic [3:0] awaddr, araddr, wstrb, hsFlags;
   logic [31:0] wdata, rdata, d;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, originate, txSilent, loopbackTestOn;
   logic [1:0] bresp, rresp, r, guardTone;
   logic [11:0] feRead1Data, feRead2Data;
   modem_cmd_pkg::rate_type rateMode;
   logic [4:0] txAttenDb;
   logic [5:0] cdOnDbm;
   logic [15:0] tone1Step, tone2Step, step;
   logic rateFallbackEnable, farEndCancellerOn, tone1Enable, tone2Enable;
   logic echoAdaptFrozen, eqAdaptFrozen, answerToneOn, scramblerOn;
   logic [7:0] b1, b2;
   logic [7:0] fz [4] = '{8'h16, 8'h17, 8'h1B, 8'h1C};
   int fails, checked, i, a, e;
   modem_cmd_if link();
   modem_cmd_host modem_cmd_host_inst (.*);
   modem_cmd_device modem_cmd_device_inst (.*, .cdOffDbm(),
      .forceCleardown(), .tone1HighAtten(), .tone2HighAtten(),
      .handshakeStart(), .handshakeRunning(), .initPulse(),
      .retrainStart(), .retrainFallback(), .cmdDone());
   modem_cmd_checker modem_cmd_checker_inst (.clock(clock),
      .arst_n(arst_n), .cmdValid(link.cmdValid), .cmdByte(link.cmdByte),
      .cmdReady(link.cmdReady), .respValid(link.respValid),
      .respByte(link.respByte), .respReady(link.respReady));
   // Clock and watchdog
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   initial begin
      #500000;
      fails++;
      summarize();
   end
   task automatic chk(input string n, input logic [31:0] x, y);
      checked++;
      if (y !== x) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", n, x, y);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Bus cycles: offer, hold until taken, await answer
   task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
      awaddr <= ad;
      wdata <= dt;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clock); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clock); while (bvalid !== 1'b1);
   endtask
   task automatic rd(input logic [3:0] ad, output logic [31:0] dt,
         output logic [1:0] rs);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
      dt = rdata;
      rs = rresp;
   endtask
   task automatic send(input logic [7:0] op, x, y);
      wr(4'h0, {8'h00, op, x, y});
      do rd(4'h4, d, r); while (d[0] !== 1'b0);
   endtask
   // Main sequence
   initial begin
      {awvalid, wvalid, arvalid, handshakeDone} = '0;
      {bready, rready} = 2'b11;
      {awaddr, araddr, wstrb, wdata} = '0;
      clockEnable = 1'b1;
      arst_n = 1'b0;
      fails = 0;
      checked = 0;
      d = $urandom(97);
      {feRead1Data, feRead2Data, hsFlags} = 28'($urandom);
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      chk("cdOn", 43, cdOnDbm);
      for (i = 0; i < 4; i++) begin
         b1 = 8'($urandom) & 8'hCF;
         b1[2:1] = 2'(i);
         b2 = 8'($urandom) & 8'hF3;
         b2[7:4] = 4'(10 + i);
         a = b2[7:4];
         send(8'h1E, b1, b2);
         chk("rate", i, rateMode);
         chk("guard", b1[7:6], guardTone);
         chk("loop", b1[3], loopbackTestOn);
         chk("orig", b1[0], originate);
         chk("atten", a > 11 ? 0 : 2 * a, txAttenDb);
         chk("silent", a > 11, txSilent);
         chk("cdOn", b2[1] ? 33 : 43, cdOnDbm);
         chk("fallback", b2[0], rateFallbackEnable);
         b1 = 8'($urandom) & 8'h3F;
         b1[2:1] = 2'(i);
         send(8'h20, b1, b2 & 8'hF0);
         chk("hsRate", 4 + {i[0], i[1]}, rateMode);
         chk("canceller", b1[4], farEndCancellerOn);
         chk("hsAtten", a > 11 ? 0 : 2 * a, txAttenDb);
         step = 16'($urandom);
         send(8'h0E + i[0], step[7:0], step[15:8]);
         chk("step", step, i[0] ? tone2Step : tone1Step);
         chk("toneOff", 0, tone1Enable | tone2Enable);
         send(fz[i], 8'h00, 8'h00);
         chk("frz", i % 2 == 0,
            i < 2 ? echoAdaptFrozen : eqAdaptFrozen);
      end
      send(8'h0D, 8'h03, 8'h00);
      chk("toneOn", 3, {tone2Enable, tone1Enable});
      e = $urandom % 2;
      send(8'h04, 8'h00, 8'(e));
      chk("answerTone", !e, answerToneOn);
      send(8'h18, 8'h00, 8'h00);
      chk("scrambler", 0, scramblerOn);
      // Third read follows a handshake-done pulse
      for (i = 0; i < 3; i++) begin
         if (i == 2) begin
            handshakeDone <= 1'b1;
            @(posedge clock);
            handshakeDone <= 1'b0;
         end
         send(8'h08 + i[0], 8'h00, 8'h00);
         rd(4'h8, d, r);
         step = i[0] ? feRead2Data : feRead1Data;
         b1 = i < 2 ? 8'hD0 : 8'hC0;
         chk("reply", {b1 | hsFlags, step[7:0], 4'h0,
            step[11:8]}, d);
      end
      send(8'h00, 8'h00, 8'h00);
      chk("nopScr", 0, scramblerOn);
      send(8'h06, 8'h00, 8'h00);
      chk("initScr", 1, scramblerOn);
      chk("initCd", 43, cdOnDbm);
      send(8'h05, 8'h00, 8'h01);
      chk("retrainDown", 1, rateMode);
      send(8'h05, 8'h00, 8'h00);
      chk("retrainUp", 0, rateMode);
      rd(4'hC, d, r);
      chk("unmapped", 2, r);
      summarize();
   end
endmodule
